// >>> rtl/cpu_memory_map_and_cache_map.vh
// Address map, region codes, cache geometry and operation codes
`ifndef CPU_MEMORY_MAP_AND_CACHE_MAP_VH
`define CPU_MEMORY_MAP_AND_CACHE_MAP_VH
// Bus split
`define IBUS_LO 32'h4000_0000
`define PBUS_LO 32'h5000_0000
// Internal memory windows, inclusive bounds
`define ROM0_LO 32'h4000_0000
`define ROM0_HI 32'h4003_FFFF
`define ROM1_I_LO 32'h4004_0000
`define ROM1_I_HI 32'h4008_FFFF
`define ROM1_D_LO 32'h3FF0_0000
`define ROM1_D_HI 32'h3FF4_FFFF
`define SRAM0_LO 32'h4037_C000
`define SRAM0_HI 32'h4037_FFFF
`define SRAM1_D_LO 32'h3FCA_0000
`define SRAM1_D_HI 32'h3FCD_FFFF
`define SRAM1_I_LO 32'h4038_0000
`define SRAM1_I_HI 32'h403B_FFFF
// External flash windows through the cache
`define CACHE_I_LO 32'h4200_0000
`define CACHE_I_HI 32'h423F_FFFF
`define CACHE_D_LO 32'h3C00_0000
`define CACHE_D_HI 32'h3C3F_FFFF
// One-hot region bit positions
`define RG_ROM0 0
`define RG_ROM1 1
`define RG_SRAM0 2
`define RG_SRAM1 3
`define RG_CACHE 4
// Access sizes
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
// Cache geometry: 4 ways x 128 sets x 8 words
`define LINE_LAST 3'h7
`define SCAN_LAST 9'h1FF
// Maintenance operation codes
`define OP_AUTO_INV 3'h0
`define OP_MAN_INV 3'h1
`define OP_LOCK 3'h2
`define OP_UNLOCK 3'h3
`define OP_PRELOAD 3'h4
`endif

// >>> rtl/cpu_memory_map_and_cache.v
// CPU address decoder with a read-only four-way flash cache and MMU
`timescale 1ns/10ps
`include "cpu_memory_map_and_cache_map.vh"

module cpu_memory_map_and_cache (
  input wire mclk,
  input wire sys_rst,
  input wire [1:0] cpu_req,
  input wire [63:0] cpu_addr,
  input wire [1:0] cpu_we,
  input wire [3:0] cpu_size,
  output wire [1:0] cpu_on_dbus,
  output wire [1:0] cpu_on_ibus,
  output wire [1:0] cpu_on_pbus,
  output wire [9:0] cpu_region,
  output wire [43:0] cpu_offset,
  output wire [7:0] cpu_be,
  output wire [1:0] cpu_err,
  output wire [1:0] cpu_wr_ok,
  output wire [1:0] cpu_ready,
  output wire [63:0] cpu_rdata,
  input wire sram0_cache_mode,
  input wire mmu_wr,
  input wire [5:0] mmu_idx,
  input wire [7:0] mmu_page,
  input wire op_req,
  input wire [2:0] op_kind,
  input wire [21:0] region_lo,
  input wire [21:0] region_hi,
  input wire [21:0] preload_addr,
  input wire auto_pl_en,
  input wire auto_pl_on_miss,
  input wire prelock_en,
  output wire op_busy,
  output wire op_done,
  output wire fl_req,
  output wire [23:0] fl_addr,
  input wire fl_valid,
  input wire [31:0] fl_rdata
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_LOOK = 4'h2;
  localparam [3:0] ST_FILL = 4'h4;
  localparam [3:0] ST_SCAN = 4'h8;

  // Inclusive window test
  function in_rng;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // Lowest set bit of a four-way mask
  function [1:0] first1;
    input [3:0] m;
    begin
      first1 = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
    end
  endfunction

  reg [3:0] st_q;
  reg pidx_q;
  reg resp_q;
  reg rr_q;
  reg [1:0] vrr_q;
  reg [1:0] way_q;
  reg [2:0] cnt_q;
  reg [8:0] scan_q;
  reg [2:0] kind_q;
  reg opact_q;
  reg op_done_q;
  reg pf_q;
  reg [21:0] pf_addr_q;
  reg [21:0] cur_q;
  reg [31:0] word_q;
  reg [63:0] rdata_q;
  reg [1:0] rdy_q;
  reg fl_req_q;
  reg [23:0] fl_addr_q;
  reg [7:0] mmu_q [0:63];
  reg [9:0] tag_q [0:511];
  reg [31:0] dmem [0:4095];
  reg [511:0] valid_q;
  reg [511:0] lock_q;
  integer i;

  wire [1:0] cwant;
  wire [43:0] voff;

  // Per-port address decode; the external memories consume these directly
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : port
      wire [31:0] a = cpu_addr[32*g+:32];
      wire [1:0] sz = cpu_size[2*g+:2];
      wire db = a < `IBUS_LO;
      wire ib = (a >= `IBUS_LO) && (a < `PBUS_LO);
      wire pb = a >= `PBUS_LO;
      wire r0 = in_rng(a, `ROM0_LO, `ROM0_HI);
      wire r1i = in_rng(a, `ROM1_I_LO, `ROM1_I_HI);
      wire r1d = in_rng(a, `ROM1_D_LO, `ROM1_D_HI);
      wire s0 = in_rng(a, `SRAM0_LO, `SRAM0_HI);
      wire s1i = in_rng(a, `SRAM1_I_LO, `SRAM1_I_HI);
      wire s1d = in_rng(a, `SRAM1_D_LO, `SRAM1_D_HI);
      wire ci = in_rng(a, `CACHE_I_LO, `CACHE_I_HI);
      wire cd = in_rng(a, `CACHE_D_LO, `CACHE_D_HI);
      wire [4:0] rg = {ci | cd, s1i | s1d, s0, r1i | r1d, r0};
      reg [31:0] base;
      wire [31:0] diff = a - base;
      // Odd sizes and misalignment are refused rather than split
      wire mis = (sz == 2'h3) || ((sz == `SZ_HALF) && a[0]) ||
        ((sz == `SZ_WORD) && (a[1:0] != 2'h0));
      wire inow = ib && (sz != `SZ_WORD);
      wire rdonly = r0 | r1i | r1d | ci | cd;
      wire bad = mis | inow | (cpu_we[g] & rdonly) |
        (s0 & sram0_cache_mode) |
        ((db | ib) & (rg == 5'h00));
      // Alias bases make equal offsets land on the same word
      always @* begin
        base = 32'h0000_0000;
        if (r0)
          base = `ROM0_LO;
        else if (r1i)
          base = `ROM1_I_LO;
        else if (r1d)
          base = `ROM1_D_LO;
        else if (s0)
          base = `SRAM0_LO;
        else if (s1i)
          base = `SRAM1_I_LO;
        else if (s1d)
          base = `SRAM1_D_LO;
        else if (ci)
          base = `CACHE_I_LO;
        else if (cd)
          base = `CACHE_D_LO;
      end
      assign cpu_on_dbus[g] = cpu_req[g] & db;
      assign cpu_on_ibus[g] = cpu_req[g] & ib;
      assign cpu_on_pbus[g] = cpu_req[g] & pb;
      assign cpu_region[5*g+:5] = cpu_req[g] ? rg : 5'h00;
      assign cpu_offset[22*g+:22] = diff[21:0];
      assign voff[22*g+:22] = diff[21:0];
      // Lowest address byte sits in lane 0
      assign cpu_be[4*g+:4] = (sz == `SZ_BYTE) ? (4'h1 << a[1:0]) :
        (sz == `SZ_HALF) ? (4'h3 << a[1:0]) : 4'hF;
      assign cpu_err[g] = cpu_req[g] & bad;
      assign cpu_wr_ok[g] = cpu_req[g] & cpu_we[g] & ~bad;
      assign cwant[g] = cpu_req[g] & rg[`RG_CACHE] & ~bad;
    end
  endgenerate

  // Lookup fields of the line under service
  wire [6:0] set = cur_q[11:5];
  wire [9:0] tag = cur_q[21:12];
  wire [3:0] hitv;
  wire [3:0] unl;
  wire [3:0] inv;

  // Tag compare per way
  genvar w;
  generate
    for (w = 0; w < 4; w = w + 1) begin : way
      localparam [1:0] WI = w;
      wire [8:0] li = {WI, set};
      assign hitv[w] = valid_q[li] && (tag_q[li] == tag);
      assign unl[w] = ~lock_q[li];
      assign inv[w] = ~valid_q[li];
    end
  endgenerate

  wire hit = |hitv;
  wire [1:0] hway = first1(hitv);

  // Victim choice: free unlocked way, else rotating unlocked, else rotating
  reg [1:0] vict;
  always @* begin
    vict = vrr_q;
    if (|(unl & inv))
      vict = first1(unl & inv);
    else if ((|unl) && !unl[vrr_q])
      vict = first1(unl);
  end

  // Region test on a virtual line address
  wire [21:0] scan_va = {tag_q[scan_q], scan_q[6:0], 5'h00};
  wire scan_in = (scan_va >= region_lo) && (scan_va <= region_hi);
  wire [21:0] line_va = {cur_q[21:5], 5'h00};
  wire fill_in = (line_va >= region_lo) && (line_va <= region_hi);
  wire [21:0] next_va = {cur_q[21:5] + 17'h0_0001, 5'h00};

  // Masking with ready stops a finished request from being served twice
  wire [1:0] want = cwant & ~rdy_q;
  wire gsel = (want == 2'h3) ? rr_q : want[1];
  wire last_beat = fl_valid && (cnt_q == `LINE_LAST);
  wire [31:0] fill_word = (cnt_q == cur_q[4:2]) ? fl_rdata : word_q;

  // Cache controller: arbitration, lookup, line fill and maintenance scan
  always @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      pidx_q <= 1'b0;
      resp_q <= 1'b0;
      rr_q <= 1'b0;
      vrr_q <= 2'h0;
      way_q <= 2'h0;
      cnt_q <= 3'h0;
      scan_q <= 9'h000;
      kind_q <= 3'h0;
      opact_q <= 1'b0;
      op_done_q <= 1'b0;
      pf_q <= 1'b0;
      pf_addr_q <= 22'h00_0000;
      cur_q <= 22'h00_0000;
      word_q <= 32'h0000_0000;
      rdata_q <= 64'h0000_0000_0000_0000;
      rdy_q <= 2'h0;
      fl_req_q <= 1'b0;
      fl_addr_q <= 24'h00_0000;
      valid_q <= {512{1'b0}};
      lock_q <= {512{1'b0}};
      for (i = 0; i < 64; i = i + 1)
        mmu_q[i] <= 8'h00;
    end else begin
      rdy_q <= 2'h0;
      op_done_q <= 1'b0;
      if (mmu_wr)
        mmu_q[mmu_idx] <= mmu_page;
      case (st_q)
        ST_IDLE: begin
          if (op_req) begin
            kind_q <= op_kind;
            opact_q <= 1'b1;
            scan_q <= 9'h000;
            resp_q <= 1'b0;
            cur_q <= preload_addr;
            st_q <= (op_kind == `OP_PRELOAD) ? ST_LOOK : ST_SCAN;
          end else if (|want) begin
            // Alternate when both buses ask in the same cycle
            pidx_q <= gsel;
            rr_q <= ~gsel;
            cur_q <= gsel ? voff[43:22] : voff[21:0];
            resp_q <= 1'b1;
            st_q <= ST_LOOK;
          end else if (pf_q) begin
            pf_q <= 1'b0;
            cur_q <= pf_addr_q;
            resp_q <= 1'b0;
            st_q <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          if (hit) begin
            if (resp_q) begin
              rdata_q[32*pidx_q+:32] <= dmem[{hway, set, cur_q[4:2]}];
              rdy_q[pidx_q] <= 1'b1;
              if (auto_pl_en && !auto_pl_on_miss) begin
                pf_q <= 1'b1;
                pf_addr_q <= next_va;
              end
            end
            op_done_q <= opact_q;
            opact_q <= 1'b0;
            st_q <= ST_IDLE;
          end else begin
            // Line is dropped first so a half-filled way never hits
            way_q <= vict;
            vrr_q <= vrr_q + 2'h1;
            valid_q[{vict, set}] <= 1'b0;
            fl_req_q <= 1'b1;
            fl_addr_q <= {mmu_q[cur_q[21:16]], cur_q[15:5], 5'h00};
            cnt_q <= 3'h0;
            st_q <= ST_FILL;
          end
        end
        ST_FILL: begin
          if (fl_valid) begin
            dmem[{way_q, set, cnt_q}] <= fl_rdata;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == cur_q[4:2])
              word_q <= fl_rdata;
          end
          if (last_beat) begin
            fl_req_q <= 1'b0;
            valid_q[{way_q, set}] <= 1'b1;
            tag_q[{way_q, set}] <= tag;
            lock_q[{way_q, set}] <= prelock_en && fill_in;
            if (resp_q) begin
              rdata_q[32*pidx_q+:32] <= fill_word;
              rdy_q[pidx_q] <= 1'b1;
              if (auto_pl_en && auto_pl_on_miss) begin
                pf_q <= 1'b1;
                pf_addr_q <= next_va;
              end
            end
            op_done_q <= opact_q;
            opact_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        ST_SCAN: begin
          // One line per cycle keeps the tag array single-ported
          case (kind_q)
            `OP_AUTO_INV: begin
              valid_q[scan_q] <= 1'b0;
              lock_q[scan_q] <= 1'b0;
            end
            `OP_MAN_INV: begin
              if (scan_in && !lock_q[scan_q])
                valid_q[scan_q] <= 1'b0;
            end
            `OP_LOCK: begin
              if (scan_in && valid_q[scan_q])
                lock_q[scan_q] <= 1'b1;
            end
            `OP_UNLOCK: begin
              if (scan_in)
                lock_q[scan_q] <= 1'b0;
            end
            default: begin
              lock_q[scan_q] <= lock_q[scan_q];
            end
          endcase
          scan_q <= scan_q + 9'h001;
          if (scan_q == `SCAN_LAST) begin
            op_done_q <= 1'b1;
            opact_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign cpu_ready = rdy_q;
  assign cpu_rdata = rdata_q;
  assign op_busy = opact_q;
  assign op_done = op_done_q;
  assign fl_req = fl_req_q;
  assign fl_addr = fl_addr_q;

endmodule

// >>> testbench/cpu_memory_map_and_cache_monitor.sv
// Port checks for the address decoder and the flash cache
`timescale 1ns/10ps
module cpu_memory_map_and_cache_monitor (
  input wire mclk,
  input wire sys_rst,
  input wire [1:0] cpu_req,
  input wire [63:0] cpu_addr,
  input wire [1:0] cpu_we,
  input wire [3:0] cpu_size,
  input wire sram0_cache_mode,
  input wire [1:0] cpu_on_dbus,
  input wire [1:0] cpu_on_pbus,
  input wire [9:0] cpu_region,
  input wire [43:0] cpu_offset,
  input wire [7:0] cpu_be,
  input wire [1:0] cpu_err,
  input wire [1:0] cpu_wr_ok,
  input wire [1:0] cpu_ready,
  input wire op_done,
  input wire fl_req,
  input wire [23:0] fl_addr,
  input wire fl_valid
);
  wire r0 = cpu_req[0];
  wire [31:0] a0 = cpu_addr[31:0];
  reg [3:0] beat_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Beats of the running fill; a short fill would leave a partial line valid
  always @(posedge mclk) begin
    if (sys_rst || !fl_req) begin
      beat_q <= 4'h0;
    end else if (fl_valid) begin
      beat_q <= beat_q + 4'h1;
    end
  end
  chk_data_route:
  assert property (r0 && a0[31:30] == 2'h0 |-> cpu_on_dbus[0] && !cpu_on_pbus[0])
    else $error("data bus route wrong");
  chk_periph_route:
  assert property (r0 && a0 >= 32'h5000_0000 |-> cpu_on_pbus[0] && !cpu_on_dbus[0])
    else $error("peripheral route wrong");
  chk_half_lanes:
  assert property (r0 && cpu_size[1:0] == 2'h1 && !a0[0] |-> cpu_be[3:0] == 4'h3 << a0[1:0])
    else $error("half lanes wrong");
  chk_misaligned_word:
  assert property (r0 && cpu_size[1:0] == 2'h2 && a0[1:0] != 2'h0 |-> cpu_err[0])
    else $error("misaligned word taken");
  chk_rom_write:
  assert property (r0 && cpu_we[0] && a0[31:18] == 14'h1000 |-> cpu_err[0] && !cpu_wr_ok[0])
    else $error("first rom write taken");
  chk_rom_alias:
  assert property (r0 && a0 >= 32'h3FF0_0000 && a0 <= 32'h3FF4_FFFF
    |-> cpu_region[1] && cpu_offset[21:0] == a0[21:0] - 22'h30_0000)
    else $error("second rom alias wrong");
  chk_cache_sram:
  assert property (r0 && sram0_cache_mode && a0[31:14] == 18'h100DF |-> cpu_err[0])
    else $error("cache sram reachable");
  chk_one_served:
  assert property (cpu_ready[0] |-> !cpu_ready[1])
    else $error("both ports answered");
  chk_whole_line:
  assert property ($fell(fl_req) |-> $past(beat_q) == 4'h7 && $past(fl_valid))
    else $error("fill ended early");
  chk_line_aligned:
  assert property (fl_req |-> fl_addr[4:0] == 5'h0)
    else $error("fill not line aligned");
  cover property ($fell(fl_req));
  cover property (cpu_ready[1]);
  cover property (op_done);
endmodule
bind cpu_memory_map_and_cache cpu_memory_map_and_cache_monitor
  cpu_memory_map_and_cache_monitor_inst (.*);

// >>> testbench/flash_model.sv
// Flash side model: streams a line as eight word beats with a chosen gap
`timescale 1ns/10ps
module flash_model (
  input wire mclk,
  input wire sys_rst,
  input wire fl_req,
  input wire [23:0] fl_addr,
  input wire [3:0] gap,
  output reg fl_valid,
  output reg [31:0] fl_rdata
);
  reg [3:0] beat_q;
  reg [3:0] wait_q;
  initial fl_valid = 1'b0;
  initial fl_rdata = 32'h0;
  // Idle data toggles so a stale word never looks like a fresh one
  always @(posedge mclk) begin
    fl_valid <= 1'b0;
    fl_rdata <= ~fl_rdata;
    if (sys_rst || !fl_req) begin
      beat_q <= 4'h0;
      wait_q <= 4'h0;
    end else if (beat_q < 4'h8) begin
      if (wait_q < gap) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        fl_valid <= 1'b1;
        fl_rdata <= {8'hC3, fl_addr[23:5], beat_q[2:0], 2'h0};
        beat_q <= beat_q + 4'h1;
        wait_q <= 4'h0;
      end
    end
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the address decoder and flash cache
`timescale 1ns/10ps
module testbench;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [1:0] cpu_req = 2'h0, cpu_we = 2'h0;
  reg [63:0] cpu_addr = 64'h0;
  reg [3:0] cpu_size = 4'h0, gap = 4'h0;
  reg sram0_cache_mode = 1'b0, mmu_wr = 1'b0, op_req = 1'b0, prelock_en = 1'b0;
  reg auto_pl_en = 1'b0, auto_pl_on_miss = 1'b0;
  reg [5:0] mmu_idx = 6'h0;
  reg [7:0] mmu_page = 8'h0;
  reg [2:0] op_kind = 3'h0;
  reg [21:0] region_lo = 22'h0, region_hi = 22'h0, preload_addr = 22'h0;
  wire [1:0] cpu_on_dbus, cpu_on_ibus, cpu_on_pbus, cpu_err, cpu_wr_ok, cpu_ready;
  wire [9:0] cpu_region;
  wire [43:0] cpu_offset;
  wire [7:0] cpu_be;
  wire [63:0] cpu_rdata;
  wire op_busy, op_done, fl_req, fl_valid;
  wire [23:0] fl_addr;
  wire [31:0] fl_rdata;
  integer fail_count = 0, checked = 0, cycles = 0, fills = 0, i, g, r, k;
  reg fl_req_q = 1'b0;
  reg [31:0] a;
  reg w, e;
  reg [7:0] pages [0:63];
  reg [31:0] base [0:6];
  reg [31:0] span [0:6];
  reg [2:0] rbit [0:6];
  cpu_memory_map_and_cache cpu_memory_map_and_cache_inst (.*);
  flash_model flash_model_inst (.*);
  always #5 mclk = ~mclk;
  // Count fills and cut a hang short
  always @(posedge mclk) begin
    fl_req_q <= fl_req;
    if (fl_req && !fl_req_q) fills = fills + 1;
    cycles = cycles + 1;
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  end
  task check(input string what, input [63:0] seen, input [63:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Flash word the model hands back for a virtual offset
  function [31:0] word(input [21:0] v);
    word = {8'hC3, pages[v[21:16]], v[15:2], 2'h0};
  endfunction
  // Port 0 reads the code window, port 1 the data window; nf is the fill count expected
  task rd(input [1:0] m, input [21:0] v0, input [21:0] v1, input integer nf);
    reg [1:0] got;
    integer n, f;
    begin
      f = fills;
      @(posedge mclk);
      gap <= $urandom % 3;
      cpu_req <= m;
      cpu_we <= 2'h0;
      cpu_size <= 4'hA;
      cpu_addr <= {32'h3C00_0000 | v1, 32'h4200_0000 | v0};
      got = 2'h0;
      n = 0;
      while (got != m && n < 300) begin
        @(posedge mclk);
        cpu_req <= m & ~got;
        #1;
        got = got | cpu_ready;
        n = n + 1;
      end
      @(posedge mclk);
      cpu_req <= 2'h0;
      check("ready", got, m);
      check("fills", fills - f, nf);
      if (m[0]) check("rdata0", cpu_rdata[31:0], word(v0));
      if (m[1]) check("rdata1", cpu_rdata[63:32], word(v1));
    end
  endtask
  task op(input [2:0] kd, input [21:0] lo, input [21:0] hi);
    integer n;
    begin
      @(posedge mclk);
      op_req <= 1'b1;
      op_kind <= kd;
      region_lo <= lo;
      region_hi <= hi;
      preload_addr <= lo;
      @(posedge mclk);
      op_req <= 1'b0;
      #1;
      check("op_busy", op_busy, 1'b1);
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end while (!op_done && n < 700);
      check("op_done", op_done, 1'b1);
      check("op_idle", op_busy, 1'b0);
    end
  endtask
  initial begin
    base = '{32'h4000_0000, 32'h4004_0000, 32'h3FF0_0000, 32'h4037_C000,
             32'h3FCA_0000, 32'h4038_0000, 32'h4200_0000};
    span = '{32'h40000, 32'h50000, 32'h50000, 32'h4000, 32'h40000, 32'h40000, 32'h400000};
    rbit = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4};
    void'($urandom(32'h77BD));
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    // Random decode; the cache window is only written, so no read is left hanging
    for (i = 0; i < 200; i = i + 1) begin
      r = $urandom % 7;
      g = i % 2;
      a = base[r] + ($urandom % span[r]) & 32'hFFFF_FFFC;
      w = r == 6 || $urandom % 2;
      if (i % 5 == 0) a = $urandom;
      if (i % 5 == 0) w = 1'b1;
      @(posedge mclk);
      cpu_req <= 2'h1 << g;
      cpu_we <= {w, w};
      cpu_size <= 4'hA;
      cpu_addr <= {a, a};
      sram0_cache_mode <= $urandom % 2;
      #1;
      e = w && (r < 3 || r == 6) || sram0_cache_mode && r == 3;
      check("bus", {cpu_on_pbus[g], cpu_on_ibus[g], cpu_on_dbus[g]},
            a < 32'h4000_0000 ? 3'h1 : a < 32'h5000_0000 ? 3'h2 : 3'h4);
      if (i % 5) check("region", cpu_region[5 * g +: 5], 5'h1 << rbit[r]);
      if (i % 5) check("offset", cpu_offset[22 * g +: 22], a - base[r]);
      if (i % 5) check("refused", {cpu_err[g], cpu_wr_ok[g]}, {e, w && !e});
    end
    // Every size at every byte offset of a data word
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge mclk);
      cpu_req <= 2'h1;
      cpu_size <= i[3:2];
      cpu_addr <= 64'h3FCA_0100 + i[1:0];
      #1;
      e = i[3:2] == 2'h3 || i[2] && i[0] || i[3] && i[1:0] != 2'h0;
      check("misaligned", cpu_err[0], e);
      if (!e) check("lanes", cpu_be[3:0], (i[3] ? 4'hF : i[2] ? 4'h3 : 4'h1) << i[1:0]);
    end
    for (i = 0; i < 64; i = i + 1) begin
      @(posedge mclk);
      pages[i] = $urandom;
      cpu_req <= 2'h0;
      mmu_wr <= 1'b1;
      mmu_idx <= i;
      mmu_page <= pages[i];
    end
    @(posedge mclk);
    mmu_wr <= 1'b0;
    rd(2'h1, 22'h01_2340, 22'h0, 1);
    rd(2'h2, 22'h0, 22'h01_2340, 0);
    rd(2'h3, 22'h02_0040, 22'h23_0080, 2);
    op(3'h1, 22'h01_2340, 22'h01_235F);
    rd(2'h1, 22'h01_2344, 22'h0, 1);
    op(3'h2, 22'h01_2340, 22'h01_2340);
    op(3'h1, 22'h0, 22'h3F_FFFF);
    rd(2'h1, 22'h01_2340, 22'h0, 0);
    rd(2'h2, 22'h0, 22'h02_0040, 1);
    op(3'h3, 22'h0, 22'h3F_FFFF);
    op(3'h1, 22'h0, 22'h3F_FFFF);
    rd(2'h1, 22'h01_2340, 22'h0, 1);
    op(3'h4, 22'h15_0000, 22'h0);
    rd(2'h2, 22'h0, 22'h15_0004, 0);
    op(3'h0, 22'h0, 22'h0);
    rd(2'h1, 22'h15_0000, 22'h0, 1);
    // Six lines of one set; only the first three fall in the prelock window
    op(3'h3, 22'h0, 22'h2FFF);
    prelock_en <= 1'b1;
    for (i = 0; i < 6; i = i + 1) rd(2'h1, i * 22'h1000, 22'h0, 1);
    prelock_en <= 1'b0;
    for (i = 0; i < 3; i = i + 1) rd(2'h1, i * 22'h1000, 22'h0, 0);
    rd(2'h1, 22'h4000, 22'h0, 1);
    auto_pl_en <= 1'b1;
    auto_pl_on_miss <= 1'b1;
    k = fills;
    rd(2'h1, 22'h30_0000, 22'h0, 1);
    for (i = 0; i < 200 && (fills != k + 2 || fl_req); i = i + 1) @(posedge mclk);
    // Preload on hit: the hit below queues the following line
    auto_pl_on_miss <= 1'b0;
    rd(2'h1, 22'h30_0020, 22'h0, 0);
    for (i = 0; i < 200 && (fills != k + 3 || fl_req); i = i + 1) @(posedge mclk);
    rd(2'h1, 22'h30_0040, 22'h0, 0);
    print_verdict;
  end
endmodule
